/* rtl/tpw_defines.svh */
// Offsets, field positions, reset values and fixed TOP values
`ifndef TPW_DEFINES_SVH
`define TPW_DEFINES_SVH
`define TPW_OFF_CTRL      6'h00
`define TPW_OFF_CMPA      6'h04
`define TPW_OFF_CMPB      6'h08
`define TPW_OFF_CAPT      6'h0C
`define TPW_OFF_STATUS    6'h10
`define TPW_OFF_COUNT     6'h14
`define TPW_OFF_PRESC     6'h18
`define TPW_CTRL_WGM_LSB  0
`define TPW_CTRL_COMA_LSB 4
`define TPW_CTRL_COMB_LSB 6
`define TPW_CTRL_DDRA_BIT 8
`define TPW_CTRL_DDRB_BIT 9
`define TPW_CTRL_PRTA_BIT 10
`define TPW_CTRL_PRTB_BIT 11
`define TPW_ST_OVF_BIT    0
`define TPW_ST_CMPA_BIT   1
`define TPW_ST_CMPB_BIT   2
`define TPW_ST_CAPT_BIT   3
`define TPW_TOP_8BIT      16'h00FF
`define TPW_TOP_9BIT      16'h01FF
`define TPW_TOP_10BIT     16'h03FF
`define TPW_ZERO16        16'h0000
`define TPW_ONES16        16'hFFFF
`define TPW_ONE16         16'h0001
`define TPW_PRESC_RST     16'h0000
`define TPW_RESP_OKAY     2'h0
`define TPW_RESP_SLVERR   2'h2
`endif

/* rtl/tpw_pkg.sv */
// Types shared by the timer PWM block
package tpw_pkg;
  typedef enum logic [3:0] {
    TPW_WGM_NORMAL  = 4'h0,
    TPW_WGM_PC8     = 4'h1,
    TPW_WGM_PC9     = 4'h2,
    TPW_WGM_PC10    = 4'h3,
    TPW_WGM_CTC_A   = 4'h4,
    TPW_WGM_FAST8   = 4'h5,
    TPW_WGM_FAST9   = 4'h6,
    TPW_WGM_FAST10  = 4'h7,
    TPW_WGM_PFC_CAP = 4'h8,
    TPW_WGM_PFC_A   = 4'h9,
    TPW_WGM_PC_CAP  = 4'hA,
    TPW_WGM_PC_A    = 4'hB,
    TPW_WGM_CTC_CAP = 4'hC,
    TPW_WGM_RSVD    = 4'hD,
    TPW_WGM_FASTCAP = 4'hE,
    TPW_WGM_FAST_A  = 4'hF
  } tpw_wgm_t;
  typedef enum logic [1:0] {
    TPW_COM_OFF    = 2'h0,
    TPW_COM_TOGGLE = 2'h1,
    TPW_COM_NONINV = 2'h2,
    TPW_COM_INV    = 2'h3
  } tpw_com_t;
  typedef enum logic [1:0] {
    TPW_BUS_IDLE = 2'h0,
    TPW_BUS_RESP = 2'h1
  } tpw_bus_state_t;
endpackage

/* rtl/tpw_prescaler.sv */
// Divider that makes the one-cycle timer clock enable
`timescale 1ns/10ps
module tpw_prescaler #(
  parameter int WIDTH = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] divide,
  output logic                  tick
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic             tick_reg;
  logic             tick_next;

  // Count to the divide value, pulse on wrap
  always_comb begin
    tick_next = 1'b0;
    cnt_next  = cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    if (cnt_reg >= divide) begin
      cnt_next  = '0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule

/* rtl/tpw_compare_unit.sv */
// One compare channel: match detect and output-compare state
`timescale 1ns/10ps
module tpw_compare_unit #(
  parameter int WIDTH = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] count,
  input  wire logic [WIDTH-1:0] compare,
  input  wire logic [1:0]       mode,
  input  wire logic             fast,
  input  wire logic             dual,
  input  wire logic             at_top,
  input  wire logic             down,
  input  wire logic             toggle_ok,
  output logic                  match,
  output logic                  state
);
  import tpw_pkg::*;
  logic state_reg;
  logic state_next;

  // Plain equality; a compare above TOP matches only when the counter runs past a missed TOP
  assign match = tick && (count == compare);

  // Output-compare state update per mode
  always_comb begin
    state_next = state_reg;
    if (tick) begin
      if (mode == TPW_COM_OFF) begin
        state_next = state_reg;
      end else if (mode == TPW_COM_TOGGLE) begin
        if (match && toggle_ok)
          state_next = ~state_reg;
      end else if (fast) begin
        // clear on match, set at wrap
        // match at TOP wins, constant level
        if (match)
          state_next = (mode == TPW_COM_INV);
        else if (at_top)
          state_next = (mode != TPW_COM_INV);
      end else if (dual) begin
        if (match)
          state_next = down ^ (mode == TPW_COM_INV);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      state_reg <= 1'b0;
    else
      state_reg <= state_next;
  end

  assign state = state_reg;
endmodule

/* rtl/tpw_timer.sv */
// Timer top: counter, TOP select, flags, pins and AXI4-Lite registers
//
// Summary of operation
// - Fast PWM counts up to selected TOP
// - At TOP counter clears next tick
// - Overflow flag set at TOP in fast, at BOTTOM in dual slope, at 0xFFFF otherwise
// - TOP register flag set when counter hits TOP
// - Each channel flags its own match
// - Fixed TOP masks high compare bits
// - Capture TOP unbuffered, may wrap past
// - Compare A buffered, loaded at TOP in PWM modes
// - Mode two non-inverted, three inverted
// - Fast: clear on match, set at wrap
// - Pin drives only when direction output
// - Fast: zero gives spike, TOP gives constant
// - Toggle mode only on channel A, with compare-A TOP
// - Phase-correct modes count up then down
// - Dual slope: up clears, down sets
// - Output mode zero leaves state alone
// - Nonzero mode overrides port value
`timescale 1ns/10ps
`include "tpw_defines.svh"
module tpw_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             compare_output_a,
  output logic             compare_output_a_oe,
  output logic             compare_output_b,
  output logic             compare_output_b_oe
);
  import tpw_pkg::*;

  logic [11:0]      ctrl_reg, ctrl_next;
  logic [WIDTH-1:0] cmpa_buf_reg, cmpa_buf_next;
  logic [WIDTH-1:0] cmpa_reg, cmpa_next;
  logic [WIDTH-1:0] cmpb_reg, cmpb_next;
  logic [WIDTH-1:0] capt_reg, capt_next;
  logic [WIDTH-1:0] presc_reg, presc_next;
  logic [WIDTH-1:0] count_reg, count_next;
  logic             down_reg, down_next;
  logic [3:0]       flags_reg, flags_next;
  logic             aw_got_reg, aw_got_next;
  logic             w_got_reg, w_got_next;
  logic [5:0]       awaddr_reg, awaddr_next;
  logic [31:0]      wdata_reg, wdata_next;
  logic             bvalid_reg, bvalid_next;
  logic [1:0]       bresp_reg, bresp_next;
  logic             rvalid_reg, rvalid_next;
  logic [31:0]      rdata_reg, rdata_next;
  logic [1:0]       rresp_reg, rresp_next;
  logic [3:0]       pins_reg, pins_next;

  tpw_wgm_t         wgm;
  logic [WIDTH-1:0] top;
  logic             fast, dual, at_top, at_bottom, tick;
  logic             match_a, match_b, state_a, state_b;
  logic [WIDTH-1:0] res_mask;
  logic             wr_fire, rd_fire;

  assign wgm = tpw_wgm_t'(ctrl_reg[`TPW_CTRL_WGM_LSB +: 4]);

  tpw_prescaler #(.WIDTH(WIDTH)) u_presc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .divide  (presc_reg),
    .tick    (tick)
  );

  // TOP and resolution mask from the generation mode
  always_comb begin
    fast     = 1'b0;
    dual     = 1'b0;
    top      = `TPW_ONES16;
    res_mask = `TPW_ONES16;
    case (wgm)
      TPW_WGM_FAST8:   begin fast = 1'b1; top = `TPW_TOP_8BIT;  end
      TPW_WGM_FAST9:   begin fast = 1'b1; top = `TPW_TOP_9BIT;  end
      TPW_WGM_FAST10:  begin fast = 1'b1; top = `TPW_TOP_10BIT; end
      TPW_WGM_FASTCAP: begin fast = 1'b1; top = capt_reg;       end
      TPW_WGM_FAST_A:  begin fast = 1'b1; top = cmpa_reg;       end
      TPW_WGM_PC8:     begin dual = 1'b1; top = `TPW_TOP_8BIT;  end
      TPW_WGM_PC9:     begin dual = 1'b1; top = `TPW_TOP_9BIT;  end
      TPW_WGM_PC10:    begin dual = 1'b1; top = `TPW_TOP_10BIT; end
      TPW_WGM_PC_CAP:  begin dual = 1'b1; top = capt_reg;       end
      TPW_WGM_PC_A:    begin dual = 1'b1; top = cmpa_reg;       end
      default:         begin top = `TPW_ONES16; end
    endcase
    if (wgm == TPW_WGM_FAST8 || wgm == TPW_WGM_PC8)
      res_mask = `TPW_TOP_8BIT;
    else if (wgm == TPW_WGM_FAST9 || wgm == TPW_WGM_PC9)
      res_mask = `TPW_TOP_9BIT;
    else if (wgm == TPW_WGM_FAST10 || wgm == TPW_WGM_PC10)
      res_mask = `TPW_TOP_10BIT;
  end

  assign at_top    = (fast || dual) && (count_reg == top);
  assign at_bottom = (count_reg == `TPW_ZERO16);

  // Counter and direction
  always_comb begin
    count_next = count_reg;
    down_next  = down_reg;
    if (tick) begin
      if (fast) begin
        // missed TOP runs on to wrap
        if (at_top)
          count_next = `TPW_ZERO16;
        else
          count_next = count_reg + `TPW_ONE16;
        down_next = 1'b0;
      end else if (dual) begin
        // up to TOP, down to BOTTOM
        if (at_top)
          down_next = 1'b1;
        else if (at_bottom)
          down_next = 1'b0;
        if ((at_top || down_reg) && !at_bottom)
          count_next = count_reg - `TPW_ONE16;
        else
          count_next = count_reg + `TPW_ONE16;
      end else begin
        count_next = count_reg + `TPW_ONE16;
        down_next  = 1'b0;
      end
    end
  end

  tpw_compare_unit #(.WIDTH(WIDTH)) u_cmp_a (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .tick      (tick),
    .count     (count_reg),
    .compare   (cmpa_reg),
    .mode      (ctrl_reg[`TPW_CTRL_COMA_LSB +: 2]),
    .fast      (fast),
    .dual      (dual),
    .at_top    (at_top),
    .down      (down_reg),
    .toggle_ok (wgm == TPW_WGM_FAST_A || wgm == TPW_WGM_PC_A),
    .match     (match_a),
    .state     (state_a)
  );

  tpw_compare_unit #(.WIDTH(WIDTH)) u_cmp_b (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .tick      (tick),
    .count     (count_reg),
    .compare   (cmpb_reg),
    .mode      (ctrl_reg[`TPW_CTRL_COMB_LSB +: 2]),
    .fast      (fast),
    .dual      (dual),
    .at_top    (at_top),
    .down      (down_reg),
    .toggle_ok (1'b0),
    .match     (match_b),
    .state     (state_b)
  );

  assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
  assign rd_fire = s_axi_arvalid && !rvalid_reg;

  // Registers, flags, compare buffer and AXI write/read channels
  always_comb begin
    ctrl_next     = ctrl_reg;
    cmpa_buf_next = cmpa_buf_reg;
    cmpa_next     = cmpa_reg;
    cmpb_next     = cmpb_reg;
    capt_next     = capt_reg;
    presc_next    = presc_reg;
    flags_next    = flags_reg;
    aw_got_next   = aw_got_reg;
    w_got_next    = w_got_reg;
    awaddr_next   = awaddr_reg;
    wdata_next    = wdata_reg;
    bvalid_next   = bvalid_reg;
    bresp_next    = bresp_reg;
    rvalid_next   = rvalid_reg;
    rdata_next    = rdata_reg;
    rresp_next    = rresp_reg;
    if (s_axi_awvalid && !aw_got_reg) begin
      aw_got_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_got_reg) begin
      w_got_next = 1'b1;
      wdata_next = s_axi_wdata;
    end
    if (wr_fire) begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = `TPW_RESP_OKAY;
      if (awaddr_reg == `TPW_OFF_CTRL)
        ctrl_next = wdata_reg[11:0];
      else if (awaddr_reg == `TPW_OFF_CMPA)
        cmpa_buf_next = wdata_reg[WIDTH-1:0] & res_mask;
      else if (awaddr_reg == `TPW_OFF_CMPB)
        cmpb_next = wdata_reg[WIDTH-1:0] & res_mask;
      else if (awaddr_reg == `TPW_OFF_CAPT)
        capt_next = wdata_reg[WIDTH-1:0];
      else if (awaddr_reg == `TPW_OFF_STATUS)
        flags_next = flags_reg & ~wdata_reg[3:0];
      else if (awaddr_reg == `TPW_OFF_PRESC)
        presc_next = wdata_reg[WIDTH-1:0];
      else
        bresp_next = `TPW_RESP_SLVERR;
    end
    if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
    if (!(fast || dual) || (tick && at_top))
      cmpa_next = cmpa_buf_reg;
    if (tick) begin
      // overflow at TOP in fast mode
      if ((fast && at_top) || (dual && at_bottom) ||
          (!fast && !dual && count_reg == `TPW_ONES16))
        flags_next[`TPW_ST_OVF_BIT] = 1'b1;
      if (match_a)
        flags_next[`TPW_ST_CMPA_BIT] = 1'b1;
      if (match_b)
        flags_next[`TPW_ST_CMPB_BIT] = 1'b1;
      if (at_top && (wgm == TPW_WGM_FAST_A || wgm == TPW_WGM_PC_A))
        flags_next[`TPW_ST_CMPA_BIT] = 1'b1;
      if (at_top && (wgm == TPW_WGM_FASTCAP || wgm == TPW_WGM_PC_CAP))
        flags_next[`TPW_ST_CAPT_BIT] = 1'b1;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next  = `TPW_RESP_OKAY;
      rdata_next  = 32'h0000_0000;
      if (s_axi_araddr == `TPW_OFF_CTRL)
        rdata_next[11:0] = ctrl_reg;
      else if (s_axi_araddr == `TPW_OFF_CMPA)
        rdata_next[WIDTH-1:0] = cmpa_buf_reg;
      else if (s_axi_araddr == `TPW_OFF_CMPB)
        rdata_next[WIDTH-1:0] = cmpb_reg;
      else if (s_axi_araddr == `TPW_OFF_CAPT)
        rdata_next[WIDTH-1:0] = capt_reg;
      else if (s_axi_araddr == `TPW_OFF_STATUS)
        rdata_next[3:0] = flags_reg;
      else if (s_axi_araddr == `TPW_OFF_COUNT)
        rdata_next[WIDTH-1:0] = count_reg;
      else if (s_axi_araddr == `TPW_OFF_PRESC)
        rdata_next[WIDTH-1:0] = presc_reg;
      else
        rresp_next = `TPW_RESP_SLVERR;
    end
    if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
  end

  // Pin values and enables
  always_comb begin
    pins_next = 4'h0;
    if (ctrl_reg[`TPW_CTRL_COMA_LSB +: 2] != TPW_COM_OFF)
      pins_next[0] = state_a;
    else
      pins_next[0] = ctrl_reg[`TPW_CTRL_PRTA_BIT];
    if (ctrl_reg[`TPW_CTRL_COMB_LSB +: 2] != TPW_COM_OFF)
      pins_next[2] = state_b;
    else
      pins_next[2] = ctrl_reg[`TPW_CTRL_PRTB_BIT];
    pins_next[1] = ctrl_reg[`TPW_CTRL_DDRA_BIT];
    pins_next[3] = ctrl_reg[`TPW_CTRL_DDRB_BIT];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg     <= 12'h000;
      cmpa_buf_reg <= `TPW_ZERO16;
      cmpa_reg     <= `TPW_ZERO16;
      cmpb_reg     <= `TPW_ZERO16;
      capt_reg     <= `TPW_ZERO16;
      presc_reg    <= `TPW_PRESC_RST;
      count_reg    <= `TPW_ZERO16;
      down_reg     <= 1'b0;
      flags_reg    <= 4'h0;
      aw_got_reg   <= 1'b0;
      w_got_reg    <= 1'b0;
      awaddr_reg   <= 6'h00;
      wdata_reg    <= 32'h0000_0000;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= `TPW_RESP_OKAY;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= 32'h0000_0000;
      rresp_reg    <= `TPW_RESP_OKAY;
      pins_reg     <= 4'h0;
    end else begin
      ctrl_reg     <= ctrl_next;
      cmpa_buf_reg <= cmpa_buf_next;
      cmpa_reg     <= cmpa_next;
      cmpb_reg     <= cmpb_next;
      capt_reg     <= capt_next;
      presc_reg    <= presc_next;
      count_reg    <= count_next;
      down_reg     <= down_next;
      flags_reg    <= flags_next;
      aw_got_reg   <= aw_got_next;
      w_got_reg    <= w_got_next;
      awaddr_reg   <= awaddr_next;
      wdata_reg    <= wdata_next;
      bvalid_reg   <= bvalid_next;
      bresp_reg    <= bresp_next;
      rvalid_reg   <= rvalid_next;
      rdata_reg    <= rdata_next;
      rresp_reg    <= rresp_next;
      pins_reg     <= pins_next;
    end
  end

  assign s_axi_awready       = !aw_got_reg;
  assign s_axi_wready        = !w_got_reg;
  assign s_axi_bvalid        = bvalid_reg;
  assign s_axi_bresp         = bresp_reg;
  assign s_axi_arready       = !rvalid_reg;
  assign s_axi_rvalid        = rvalid_reg;
  assign s_axi_rdata         = rdata_reg;
  assign s_axi_rresp         = rresp_reg;
  assign compare_output_a    = pins_reg[0];
  assign compare_output_a_oe = pins_reg[1];
  assign compare_output_b    = pins_reg[2];
  assign compare_output_b_oe = pins_reg[3];
endmodule

/* dv/tpw_load.sv */
// External load model hanging on one compare output pin
`timescale 1ns/10ps
module tpw_load (
  input  wire logic        aclk,
  input  wire logic        pin,
  input  wire logic        oe,
  input  wire logic        clr,
  output logic      [15:0] high_cnt
);
  logic level;
  assign level = oe ? pin : 1'b0; // Pull-down on a released pin
  // Count the cycles the load sees high
  always_ff @(posedge aclk) begin
    if (clr) high_cnt <= 16'h0000;
    else if (level) high_cnt <= high_cnt + 16'h0001;
  end
endmodule

/* dv/tpw_timer_assertions.sv */
// Bus and pin checks on the timer top ports
`timescale 1ns/10ps
module tpw_timer_assertions #(
  parameter int WIDTH = 16
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [5:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [5:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        compare_output_a,
  input wire logic        compare_output_a_oe,
  input wire logic        compare_output_b,
  input wire logic        compare_output_b_oe
);
  logic [5:0]  aw_q;
  logic [31:0] w_q;
  logic [31:0] ctrl_sh;
  logic [1:0]  since;
  logic        bv_q;
  // Shadow of the control word, settle counter after each control write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 6'h00;
      w_q <= 32'h00000000;
      ctrl_sh <= 32'h00000000;
      since <= 2'h0;
      bv_q <= 1'b0;
    end else begin
      bv_q <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata;
      if (s_axi_bvalid && !bv_q && aw_q == 6'h00
          && s_axi_bresp == 2'h0) begin
        ctrl_sh <= w_q;
        since <= 2'h0;
      end else if (since != 2'h3) since <= since + 2'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response lost");
  wr_unmapped_a: assert property (wr_taken ##0 s_axi_awaddr > 6'h18 |->
    ##2 s_axi_bresp == 2'h2) else $error("unmapped write not refused");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read response missing");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read response changed");
  rd_unmapped_a: assert property (rd_taken ##0 s_axi_araddr > 6'h18 |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  pin_dir_a: assert property (since == 2'h3 |->
    compare_output_a_oe == ctrl_sh[8] && compare_output_b_oe == ctrl_sh[9])
    else $error("pin enable differs from direction");
  port_pass_a: assert property (
    since == 2'h3 && ctrl_sh[5:4] == 2'h0 |-> compare_output_a == ctrl_sh[10])
    else $error("pin A not port value");
  port_b_pass_a: assert property (
    since == 2'h3 && ctrl_sh[7:6] == 2'h0 |-> compare_output_b == ctrl_sh[11])
    else $error("pin B not port value");
  reset_pins_a: assert property ($rose(aresetn) |-> !compare_output_a
    && !compare_output_b && !compare_output_a_oe && !compare_output_b_oe)
    else $error("pins not cleared by reset");
endmodule
bind tpw_timer tpw_timer_assertions #(.WIDTH(WIDTH)) u_tpw_timer_assertions (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .compare_output_a,
  .compare_output_a_oe, .compare_output_b, .compare_output_b_oe);

/* dv/test_timer16_fast_and_dual_slope_pwm.sv */
// Self-checking bench for the timer PWM block
`timescale 1ns/10ps
module test_timer16_fast_and_dual_slope_pwm;
  typedef struct {logic [31:0] d, m; logic [1:0] r;} tpw_note_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, ld_clr;
  logic compare_output_a, compare_output_a_oe;
  logic compare_output_b, compare_output_b_oe;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] ha, hb;
  tpw_note_t   exp_q[$];
  int          bad_count, n_tests, cyc, k, h;
  tpw_timer #(.WIDTH(16)) u_tpw_timer (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .compare_output_a,
    .compare_output_a_oe, .compare_output_b, .compare_output_b_oe);
  tpw_load u_tpw_load_a (.aclk(aclk), .pin(compare_output_a),
    .oe(compare_output_a_oe), .clr(ld_clr), .high_cnt(ha));
  tpw_load u_tpw_load_b (.aclk(aclk), .pin(compare_output_b),
    .oe(compare_output_b_oe), .clr(ld_clr), .high_cnt(hb));
  // Clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, m,
                    input logic [1:0] r);
    exp_q.push_back('{e, m, r});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic meas(input logic b, input int w, input int e);
    @(posedge aclk);
    ld_clr <= 1'b1;
    @(posedge aclk);
    ld_clr <= 1'b0;
    idle(w);
    #1;
    check("pin_high", {16'h0000, b ? hb : ha}, 32'(e));
  endtask
  // Read monitor takes the oldest note
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      if (exp_q.size() == 0) check("read_note", 32'h00000000, 32'h00000001);
      else begin
        check("rdata", s_axi_rdata & exp_q[0].m, exp_q[0].d);
        check("rresp", {30'h0, s_axi_rresp}, {30'h0, exp_q[0].r});
        void'(exp_q.pop_front());
      end
    end
  end
  // Hang guard
  initial begin
    cyc = 0;
    forever begin
      @(posedge aclk);
      cyc++;
      if (cyc == 40000) begin
        bad_count++;
        end_sim();
      end
    end
  end
  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, ld_clr} = 3'h0;
    s_axi_awaddr = 6'h00;
    s_axi_araddr = 6'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    void'($urandom(32'h711b87b1));
    idle(3);
    aresetn <= 1'b1;
    rd(6'h00, 32'h00000000, 32'hFFFFFFFF, 2'h0);
    rd(6'h1C, 32'h00000000, 32'hFFFFFFFF, 2'h2);
    wr(6'h1C, 32'h0000FFFF);
    for (int m = 7; m >= 5; m--) begin
      wr(6'h00, 32'(m));
      wr(6'h08, 32'h0000FFFF);
      rd(6'h08, 32'((1 << (m + 3)) - 1), 32'hFFFFFFFF, 2'h0);
    end
    for (int p = 2; p <= 3; p++) begin
      for (int i = 0; i < 3; i++) begin
        k = (i == 0) ? 0 : (i == 1) ? 1 + $urandom % 254 : 255;
        h = (k == 255) ? 0 : 2 * (k + 1);
        wr(6'h08, 32'(k));
        wr(6'h00, 32'h00000A05 | 32'(p << 6));
        idle(520);
        meas(1'b1, 512, (p == 2) ? h : 512 - h);
      end
    end
    wr(6'h00, 32'h00000A05);
    meas(1'b1, 64, 64);
    wr(6'h00, 32'h00000885);
    meas(1'b1, 64, 0);
    wr(6'h04, 32'h000000FF);
    idle(300);
    wr(6'h00, 32'h0000000F);
    wr(6'h04, 32'h00000003);
    idle(300);
    repeat (4) rd(6'h14, 32'h0, 32'h0000FFFC, 2'h0);
    wr(6'h10, 32'h0000000F);
    idle(8);
    rd(6'h10, 32'h3, 32'h7, 2'h0);
    wr(6'h00, 32'h0000011F);
    idle(16);
    meas(1'b0, 64, 32);
    wr(6'h0C, 32'h00000003);
    wr(6'h00, 32'h0000000E);
    wr(6'h0C, 32'h00000009);
    wr(6'h08, 32'h00000004);
    idle(30);
    wr(6'h10, 32'h0000000F);
    idle(12);
    rd(6'h10, 32'hD, 32'hD, 2'h0);
    wr(6'h00, 32'h00000A8E);
    idle(20);
    meas(1'b1, 40, 20);
    for (int p = 2; p <= 3; p++) begin
      wr(6'h00, 32'h00000A0A | 32'(p << 6));
      idle(40);
      meas(1'b1, 36, (p == 2) ? 16 : 20);
    end
    idle(4);
    end_sim();
  end
endmodule
